// File: hw/arz_seq.sv
// Reclose sequencer with manual-close blocking and zone coordination
//
// What this block does
// RULE1: Trip during close block opens breaker; timer continues
// RULE2: Close block expiry with breaker open: standby
// RULE3: Zone coordination enabled by activation setting
// RULE4: Zone mode reuses normal shot and timer settings
// RULE5: Zone mode dead time starts without local trip
// RULE6: Zone dead time starts on pickup falling edge
// RULE7: Zone dead expiry increments shot, starts reclaim
// RULE8: Shot number selects renewed pickup thresholds
// RULE9: Transient zone fault resets at reclaim expiry
// RULE10: Breaker close in standby starts block, transit
// RULE11: Confirm breaker open within supervision window
// RULE12: Increment shot counter before reclose command
// RULE13: Lockout exits after reset signal then timer
// RULE14: Timers are tick-driven preset down-counters
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "arz_regs.svh"

module arz_seq import arz_pkg::*; #(
    parameter int TICK_CYC = `ARZ_TICK_CYC,
    parameter int TW = `ARZ_TMR_W,
    parameter int SW = `ARZ_SHOT_W
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`ARZ_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BKR_CLOSED,
    input wire logic PROT_PICKUP,
    input wire logic PROT_TRIP,
    output logic BKR_TRIP,
    output logic BKR_CLOSE,
    output logic [SW-1:0] SHOT_NUM,
    output logic IRQ
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    arz_prot_t meta_r;
    arz_prot_t sync_r;
    arz_prot_t prev_r;
    always_ff @(posedge CLK) begin
        meta_r <= '{pickup: PROT_PICKUP, trip: PROT_TRIP, bkr_closed: BKR_CLOSED};
        sync_r <= meta_r;
        prev_r <= sync_r;
    end
    wire pickup_fall_w = prev_r.pickup && !sync_r.pickup;
    wire close_rise_w = !prev_r.bkr_closed && sync_r.bkr_closed;

    // ---------------------------------------------------------------
    // Settings registers
    // ---------------------------------------------------------------
    logic en_r, zone_r, lorst_r;
    logic [SW-1:0] max_shots_r;
    logic [TW-1:0] dead_r, mcb_r, reclaim_r, fault_r, close_r, lor_r;
    logic [`ARZ_IRQ_W-1:0] irq_st_r, irq_msk_r, irq_ev;
    arz_state_t state_r, state_nxt;

    wire wr_w = PSEL && PENABLE && PWRITE;
    wire rd_w = PSEL && PENABLE && !PWRITE;
    wire sel_ctrl = PADDR == `ARZ_CTRL_OFS;
    wire sel_shots = PADDR == `ARZ_SHOTS_OFS;
    wire sel_dead = PADDR == `ARZ_DEAD_OFS;
    wire sel_mcb = PADDR == `ARZ_MCB_OFS;
    wire sel_recl = PADDR == `ARZ_RECLAIM_OFS;
    wire sel_fault = PADDR == `ARZ_FAULT_OFS;
    wire sel_close = PADDR == `ARZ_CLOSE_OFS;
    wire sel_lor = PADDR == `ARZ_LOR_OFS;
    wire sel_state = PADDR == `ARZ_STATE_OFS;
    wire sel_ist = PADDR == `ARZ_IRQ_ST_OFS;
    wire sel_imsk = PADDR == `ARZ_IRQ_MSK_OFS;
    wire sel_any = sel_ctrl || sel_shots || sel_dead || sel_mcb || sel_recl || sel_fault
        || sel_close || sel_lor || sel_state || sel_ist || sel_imsk;

    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata_nxt = {29'h0, lorst_r, zone_r, en_r};
        end else if (sel_shots) begin
            rdata_nxt = {{(32-SW){1'b0}}, max_shots_r};
        end else if (sel_dead) begin
            rdata_nxt = {{(32-TW){1'b0}}, dead_r};
        end else if (sel_mcb) begin
            rdata_nxt = {{(32-TW){1'b0}}, mcb_r};
        end else if (sel_recl) begin
            rdata_nxt = {{(32-TW){1'b0}}, reclaim_r};
        end else if (sel_fault) begin
            rdata_nxt = {{(32-TW){1'b0}}, fault_r};
        end else if (sel_close) begin
            rdata_nxt = {{(32-TW){1'b0}}, close_r};
        end else if (sel_lor) begin
            rdata_nxt = {{(32-TW){1'b0}}, lor_r};
        end else if (sel_state) begin
            rdata_nxt = {20'h0, SHOT_NUM, 5'h0, state_r};
        end else if (sel_ist) begin
            rdata_nxt = {27'h0, irq_st_r};
        end else if (sel_imsk) begin
            rdata_nxt = {27'h0, irq_msk_r};
        end
    end

    // Zero-wait slave: PREADY rises in every access phase
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !sel_any;
            PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rdata_nxt : PRDATA;
        end
    end
    wire acc_w = PREADY;
    wire do_wr = wr_w && acc_w && sel_any;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            en_r <= 1'b0;
            zone_r <= 1'b0;
            lorst_r <= 1'b0;
            max_shots_r <= `ARZ_MAX_SHOTS_RST;
            dead_r <= `ARZ_DEAD_RST;
            mcb_r <= `ARZ_MCB_RST;
            reclaim_r <= `ARZ_RECLAIM_RST;
            fault_r <= `ARZ_FAULT_RST;
            close_r <= `ARZ_CLOSE_RST;
            lor_r <= `ARZ_LOR_RST;
            irq_msk_r <= '0;
        end else if (do_wr) begin
            if (sel_ctrl) begin
                en_r <= PWDATA[`ARZ_CTRL_EN_BIT];
                zone_r <= PWDATA[`ARZ_CTRL_ZONE_BIT]; // see RULE3
                lorst_r <= PWDATA[`ARZ_CTRL_LORST_BIT];
            end else if (sel_shots) begin
                max_shots_r <= PWDATA[SW-1:0];
            end else if (sel_dead) begin
                dead_r <= PWDATA[TW-1:0];
            end else if (sel_mcb) begin
                mcb_r <= PWDATA[TW-1:0];
            end else if (sel_recl) begin
                reclaim_r <= PWDATA[TW-1:0];
            end else if (sel_fault) begin
                fault_r <= PWDATA[TW-1:0];
            end else if (sel_close) begin
                close_r <= PWDATA[TW-1:0];
            end else if (sel_lor) begin
                lor_r <= PWDATA[TW-1:0];
            end else if (sel_imsk) begin
                irq_msk_r <= PWDATA[`ARZ_IRQ_W-1:0];
            end
        end
    end
    wire unused_rd = rd_w;

    // ---------------------------------------------------------------
    // Common tick
    // ---------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic tick_r;
    always_ff @(posedge CLK) begin
        if (SYS_RST || tick_cnt_r == 32'(TICK_CYC - 1)) begin
            tick_cnt_r <= 32'h0;
            tick_r <= !SYS_RST;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Timers
    // ---------------------------------------------------------------
    // One sequence timer shared by exclusive states; close block separate so it can run on
    logic seq_start, mcb_start, seq_run, seq_exp, mcb_run, mcb_exp;
    logic [TW-1:0] seq_preset;
    arz_timer #(.W(TW)) u_seq_tmr (
        .clk(CLK), .rst(SYS_RST), .tick(tick_r), .start(seq_start), .stop(1'b0),
        .preset(seq_preset), .running(seq_run), .expired(seq_exp)
    ); // see RULE14
    arz_timer #(.W(TW)) u_mcb_tmr (
        .clk(CLK), .rst(SYS_RST), .tick(tick_r), .start(mcb_start), .stop(1'b0),
        .preset(mcb_r), .running(mcb_run), .expired(mcb_exp)
    ); // see RULE14

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    logic [SW-1:0] shot_r, shot_nxt;
    logic zone_cycle_r, zone_cycle_nxt;
    logic trip_nxt, close_nxt;
    wire at_max_w = shot_r >= max_shots_r; // see RULE4

    always_comb begin
        state_nxt = state_r;
        shot_nxt = shot_r;
        zone_cycle_nxt = zone_cycle_r;
        seq_start = 1'b0;
        seq_preset = dead_r;
        mcb_start = 1'b0;
        trip_nxt = sync_r.trip;
        close_nxt = 1'b0;
        irq_ev = '0;
        case (state_r)
            ST_STANDBY: begin
                if (close_rise_w) begin
                    mcb_start = 1'b1; // see RULE10
                    state_nxt = ST_MCB;
                end
            end
            ST_MCB: begin
                trip_nxt = sync_r.trip; // see RULE1
                if (mcb_exp) begin
                    if (sync_r.bkr_closed) begin
                        state_nxt = ST_READY; // see RULE10
                    end else begin
                        state_nxt = ST_STANDBY; // see RULE2
                        irq_ev[`ARZ_IRQ_STBY_BIT] = 1'b1;
                    end
                end
            end
            ST_READY: begin
                if (!sync_r.bkr_closed) begin
                    state_nxt = ST_STANDBY;
                end else if (sync_r.pickup && en_r) begin
                    seq_preset = fault_r;
                    seq_start = 1'b1;
                    zone_cycle_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (zone_r && pickup_fall_w && !sync_r.trip) begin
                    seq_preset = dead_r; // see RULE5
                    seq_start = 1'b1; // see RULE6
                    zone_cycle_nxt = 1'b1;
                    state_nxt = ST_DEAD;
                end else if (sync_r.trip) begin
                    seq_preset = TW'(`ARZ_BRK_SUP_TICKS);
                    seq_start = 1'b1;
                    state_nxt = ST_WAIT_OPEN;
                end else if (seq_exp) begin
                    state_nxt = ST_LOCKOUT;
                    irq_ev[`ARZ_IRQ_LOCK_BIT] = 1'b1;
                end
            end
            ST_WAIT_OPEN: begin
                if (!sync_r.bkr_closed) begin
                    seq_preset = dead_r; // see RULE11
                    seq_start = 1'b1;
                    zone_cycle_nxt = 1'b0;
                    state_nxt = ST_DEAD;
                end else if (seq_exp) begin
                    state_nxt = ST_LOCKOUT; // see RULE11
                    irq_ev[`ARZ_IRQ_LOCK_BIT] = 1'b1;
                end
            end
            ST_DEAD: begin
                if (seq_exp) begin
                    shot_nxt = shot_r + SW'(1); // see RULE12
                    irq_ev[`ARZ_IRQ_SHOT_BIT] = 1'b1;
                    if (zone_cycle_r) begin
                        seq_preset = reclaim_r; // see RULE7
                        seq_start = 1'b1;
                        state_nxt = ST_RECLAIM;
                    end else if (sync_r.pickup || sync_r.trip || sync_r.bkr_closed) begin
                        state_nxt = ST_LOCKOUT;
                        irq_ev[`ARZ_IRQ_LOCK_BIT] = 1'b1;
                    end else begin
                        close_nxt = 1'b1;
                        seq_preset = close_r;
                        seq_start = 1'b1;
                        state_nxt = ST_RECLOSE;
                    end
                end
            end
            ST_RECLOSE: begin
                close_nxt = 1'b1;
                if (sync_r.bkr_closed) begin
                    close_nxt = 1'b0;
                    seq_preset = reclaim_r;
                    seq_start = 1'b1;
                    state_nxt = ST_RECLAIM;
                end else if (seq_exp) begin
                    close_nxt = 1'b0;
                    state_nxt = ST_LOCKOUT;
                    irq_ev[`ARZ_IRQ_LOCK_BIT] = 1'b1;
                end
            end
            ST_RECLAIM: begin
                // Renewed pickup runs under SHOT_NUM, which now holds the raised count
                if (sync_r.pickup) begin
                    if (at_max_w) begin
                        state_nxt = ST_LOCKOUT;
                        irq_ev[`ARZ_IRQ_LOCK_BIT] = 1'b1;
                    end else begin
                        seq_preset = fault_r; // see RULE8
                        seq_start = 1'b1;
                        state_nxt = ST_RUN;
                    end
                end else if (seq_exp) begin
                    shot_nxt = '0; // see RULE9
                    state_nxt = ST_READY;
                    irq_ev[`ARZ_IRQ_DONE_BIT] = 1'b1;
                end
            end
            ST_LOCKOUT: begin
                if (lorst_r) begin
                    seq_preset = lor_r;
                    seq_start = 1'b1;
                    state_nxt = ST_LOR_WAIT;
                end
            end
            ST_LOR_WAIT: begin
                if (seq_exp) begin
                    shot_nxt = '0; // see RULE13
                    state_nxt = sync_r.bkr_closed ? ST_READY : ST_STANDBY;
                end
            end
            default: begin
                state_nxt = ST_STANDBY;
            end
        endcase
        irq_ev[`ARZ_IRQ_CLOSE_BIT] = close_rise_w;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= ST_STANDBY;
            shot_r <= '0;
            zone_cycle_r <= 1'b0;
            BKR_TRIP <= 1'b0;
            BKR_CLOSE <= 1'b0;
            SHOT_NUM <= '0;
        end else begin
            state_r <= state_nxt;
            shot_r <= shot_nxt;
            zone_cycle_r <= zone_cycle_nxt;
            BKR_TRIP <= trip_nxt; // see RULE1
            BKR_CLOSE <= close_nxt; // see RULE7
            SHOT_NUM <= shot_nxt; // see RULE8
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    // Set beats write-one-to-clear in the same cycle
    wire [`ARZ_IRQ_W-1:0] w1c_w = (do_wr && sel_ist) ? PWDATA[`ARZ_IRQ_W-1:0] : '0;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            irq_st_r <= '0;
            IRQ <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~w1c_w) | irq_ev;
            IRQ <= |(((irq_st_r & ~w1c_w) | irq_ev) & irq_msk_r);
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_mcb_trip;
        @(posedge CLK) disable iff (SYS_RST)
        (state_r == ST_MCB && sync_r.trip && !mcb_exp) |=> BKR_TRIP && (mcb_run || mcb_exp);
    endproperty
    a_mcb_trip: assert property (p_mcb_trip) else $error("trip not passed during block"); // see RULE1

    property p_mcb_open;
        @(posedge CLK) disable iff (SYS_RST)
        (state_r == ST_MCB && mcb_exp && !sync_r.bkr_closed) |=> state_r == ST_STANDBY;
    endproperty
    a_mcb_open: assert property (p_mcb_open) else $error("block expiry did not standby"); // see RULE2

    property p_zone_off;
        @(posedge CLK) disable iff (SYS_RST)
        (state_r == ST_DEAD && $past(state_r) == ST_RUN) |-> $past(zone_r);
    endproperty
    a_zone_off: assert property (p_zone_off) else $error("zone dead without setting"); // see RULE3

    property p_zone_dead;
        @(posedge CLK) disable iff (SYS_RST)
        (state_r == ST_RUN && zone_r && pickup_fall_w && !sync_r.trip)
            |=> state_r == ST_DEAD && seq_run; // see RULE5
    endproperty
    a_zone_dead: assert property (p_zone_dead) else $error("zone dead time not started"); // see RULE6

    property p_zone_shot;
        @(posedge CLK) disable iff (SYS_RST)
        (state_r == ST_DEAD && zone_cycle_r && seq_exp)
            |=> shot_r == $past(shot_r) + SW'(1) && state_r == ST_RECLAIM && !BKR_CLOSE;
    endproperty
    a_zone_shot: assert property (p_zone_shot) else $error("zone shot step wrong"); // see RULE7

    property p_shot_first;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(BKR_CLOSE) |-> SHOT_NUM == $past(shot_r) + SW'(1);
    endproperty
    a_shot_first: assert property (p_shot_first) else $error("close before shot step"); // see RULE12

    property p_lor;
        @(posedge CLK) disable iff (SYS_RST)
        ($past(state_r) == ST_LOCKOUT && state_r != ST_LOCKOUT) |-> state_r == ST_LOR_WAIT;
    endproperty
    a_lor: assert property (p_lor) else $error("lockout left early"); // see RULE13

    property p_mcb_enter;
        @(posedge CLK) disable iff (SYS_RST)
        (state_r == ST_STANDBY && close_rise_w) |=> state_r == ST_MCB ##1 mcb_run;
    endproperty
    a_mcb_enter: assert property (p_mcb_enter) else $error("standby close not handled"); // see RULE10

endmodule : arz_seq

// File: pkg/arz_regs.svh
// Register offsets, field positions, reset values and timing counts for the reclose sequencer
`ifndef ARZ_REGS_SVH
`define ARZ_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ARZ_CTRL_OFS     12'h000
`define ARZ_SHOTS_OFS    12'h004
`define ARZ_DEAD_OFS     12'h008
`define ARZ_MCB_OFS      12'h00C
`define ARZ_RECLAIM_OFS  12'h010
`define ARZ_FAULT_OFS    12'h014
`define ARZ_CLOSE_OFS    12'h018
`define ARZ_LOR_OFS      12'h01C
`define ARZ_STATE_OFS    12'h020
`define ARZ_IRQ_ST_OFS   12'h024
`define ARZ_IRQ_MSK_OFS  12'h028
`define ARZ_ADDR_W       12

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define ARZ_CTRL_EN_BIT    0
`define ARZ_CTRL_ZONE_BIT  1
`define ARZ_CTRL_LORST_BIT 2

// ---------------------------------------------------------------
// Interrupt status bits
// ---------------------------------------------------------------
`define ARZ_IRQ_W          5
`define ARZ_IRQ_SHOT_BIT   0
`define ARZ_IRQ_LOCK_BIT   1
`define ARZ_IRQ_DONE_BIT   2
`define ARZ_IRQ_STBY_BIT   3
`define ARZ_IRQ_CLOSE_BIT  4

// ---------------------------------------------------------------
// Timing and reset values
// ---------------------------------------------------------------
`define ARZ_CLK_MHZ        100
`define ARZ_TICK_US        1000
`define ARZ_TICK_CYC       (`ARZ_TICK_US * `ARZ_CLK_MHZ)
`define ARZ_BRK_SUP_MS     200
`define ARZ_BRK_SUP_TICKS  (`ARZ_BRK_SUP_MS * 1000 / `ARZ_TICK_US)
`define ARZ_TMR_W          16
`define ARZ_SHOT_W         3
`define ARZ_MAX_SHOTS_RST  3'h2
`define ARZ_DEAD_RST       16'h01F4
`define ARZ_MCB_RST        16'h03E8
`define ARZ_RECLAIM_RST    16'h1388
`define ARZ_FAULT_RST      16'h03E8
`define ARZ_CLOSE_RST      16'h00C8
`define ARZ_LOR_RST        16'h0064

`endif

// File: pkg/arz_pkg.sv
// Types for the reclose sequencer
package arz_pkg;

    // ---------------------------------------------------------------
    // Sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_STANDBY,
        ST_MCB,
        ST_READY,
        ST_RUN,
        ST_WAIT_OPEN,
        ST_DEAD,
        ST_RECLOSE,
        ST_RECLAIM,
        ST_LOCKOUT,
        ST_LOR_WAIT
    } arz_state_t;

    // ---------------------------------------------------------------
    // Protection inputs grouped together
    // ---------------------------------------------------------------
    typedef struct packed {
        logic pickup;
        logic trip;
        logic bkr_closed;
    } arz_prot_t;

endpackage : arz_pkg

// File: hw/arz_timer.sv
// Tick-driven down-counting timer for the reclose sequencer
`timescale 1ns/1ps
`include "arz_regs.svh"

module arz_timer import arz_pkg::*; #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic [W-1:0] preset,
    output logic running,
    output logic expired
);

    logic [W-1:0] cnt_r;
    logic run_r;
    logic exp_r;
    wire last_w = run_r && tick && (cnt_r <= W'(1));

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    // Preset loads on start, counts down on tick
    always_ff @(posedge clk) begin
        if (rst || stop) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else if (start) begin
            cnt_r <= preset;
            run_r <= 1'b1;
            exp_r <= 1'b0;
        end else begin
            exp_r <= last_w;
            if (last_w) begin
                run_r <= 1'b0;
                cnt_r <= '0;
            end else if (run_r && tick) begin
                cnt_r <= cnt_r - W'(1);
            end
        end
    end

    assign running = run_r;
    assign expired = exp_r;

endmodule : arz_timer

// File: dv/arz_brk_model.sv
// Breaker model: opens on trip command, closes on reclose or manual close
`timescale 1ns/1ps

module arz_brk_model (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic BKR_TRIP,
    input wire logic BKR_CLOSE,
    input wire logic MAN_CLOSE,
    output logic BKR_CLOSED
);
    // Trip wins over close, as a real breaker with anti-pump would behave
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            BKR_CLOSED <= 1'b0;
        end else if (BKR_TRIP) begin
            BKR_CLOSED <= 1'b0;
        end else if (BKR_CLOSE || MAN_CLOSE) begin
            BKR_CLOSED <= 1'b1;
        end
    end
endmodule : arz_brk_model

// File: dv/autoreclose_zone_coordination_tb.sv
// Testbench for the reclose sequencer: APB tasks, breaker model, sequence checks
`timescale 1ns/1ps
`include "arz_regs.svh"

module autoreclose_zone_coordination_tb;
    logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic PREADY, PSLVERR, BKR_CLOSED, PROT_PICKUP = 0, PROT_TRIP = 0, MAN_CLOSE = 0;
    logic BKR_TRIP, BKR_CLOSE, IRQ;
    logic [2:0] SHOT_NUM;
    logic slverr_q;
    int errors = 0, comparisons = 0;
    logic [11:0] ofs [7] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
    logic [31:0] rv [7] = '{32'h2, 32'h1F4, 32'h3E8, 32'h1388, 32'h3E8, 32'hC8, 32'h64};

    always #5 CLK = ~CLK;

    arz_seq #(.TICK_CYC(10)) u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .BKR_CLOSED(BKR_CLOSED), .PROT_PICKUP(PROT_PICKUP),
        .PROT_TRIP(PROT_TRIP), .BKR_TRIP(BKR_TRIP), .BKR_CLOSE(BKR_CLOSE),
        .SHOT_NUM(SHOT_NUM), .IRQ(IRQ));
    arz_brk_model u_brk (.CLK(CLK), .SYS_RST(SYS_RST), .BKR_TRIP(BKR_TRIP),
        .BKR_CLOSE(BKR_CLOSE), .MAN_CLOSE(MAN_CLOSE), .BKR_CLOSED(BKR_CLOSED));

    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Holds the request until PREADY is sampled high; a missing answer ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            errors++;
            results();
        end
        q = PRDATA;
        slverr_q = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        // One idle edge so the next call never reassigns PSEL in this time step
        @(posedge CLK);
    endtask : apb

    // Polls the state field; the bound stands in for an open-ended wait
    task automatic wait_st(input logic [3:0] st);
        int n;
        for (n = 0; n < 400; n++) begin
            apb(0, 12'h020, 0);
            if (q[3:0] === st) break;
        end
        chk("state", {28'h0, st}, {28'h0, q[3:0]});
        if (q[3:0] !== st) begin
            results();
        end
    endtask : wait_st

    initial begin
        repeat (4) @(posedge CLK);
        SYS_RST <= 0;
        @(posedge CLK);
        for (int i = 0; i < 7; i++) begin
            apb(0, ofs[i], 0);
            chk("reset value", rv[i], q);
        end
        apb(0, 12'h0FC, 0);
        chk("unmapped", 32'h1, {31'h0, slverr_q});
        apb(1, 12'h008, 3); apb(1, 12'h00C, 4); apb(1, 12'h010, 5); apb(1, 12'h000, 1);
        // Manual close, then a trip while the block timer runs
        MAN_CLOSE <= 1; @(posedge CLK); MAN_CLOSE <= 0;
        wait_st(4'h1);
        PROT_TRIP <= 1; repeat (6) @(posedge CLK);
        chk("trip", 32'h1, {31'h0, BKR_TRIP});
        chk("breaker", 32'h0, {31'h0, BKR_CLOSED});
        PROT_TRIP <= 0;
        apb(0, 12'h020, 0);
        chk("state", 32'h1, {28'h0, q[3:0]});
        wait_st(4'h0);
        // Close again and reach ready, then run a zone coordinated shot
        MAN_CLOSE <= 1; @(posedge CLK); MAN_CLOSE <= 0;
        wait_st(4'h2);
        apb(1, 12'h000, 3);
        PROT_PICKUP <= 1;
        wait_st(4'h3);
        PROT_PICKUP <= 0;
        wait_st(4'h5);
        wait_st(4'h7);
        chk("shot", 32'h1, {29'h0, SHOT_NUM});
        chk("close", 32'h0, {31'h0, BKR_CLOSE});
        chk("breaker", 32'h1, {31'h0, BKR_CLOSED});
        wait_st(4'h2);
        chk("shot", 32'h0, {29'h0, SHOT_NUM});
        // Normal shot: local trip, breaker opens, dead time, reclose command
        apb(1, 12'h000, 1);
        PROT_PICKUP <= 1;
        PROT_TRIP <= 1;
        wait_st(4'h5);
        PROT_PICKUP <= 0;
        PROT_TRIP <= 0;
        wait_st(4'h7);
        chk("shot", 32'h1, {29'h0, SHOT_NUM});
        chk("breaker", 32'h1, {31'h0, BKR_CLOSED});
        wait_st(4'h2);
        chk("shot", 32'h0, {29'h0, SHOT_NUM});
        // Fault timer runs out into lockout, then the lockout reset path
        apb(1, 12'h014, 2);
        apb(1, 12'h01C, 3);
        PROT_PICKUP <= 1;
        wait_st(4'h8);
        PROT_PICKUP <= 0;
        apb(1, 12'h000, 5);
        wait_st(4'h9);
        wait_st(4'h2);
        // Interrupt: masked, unmasked, then cleared by writing one
        chk("irq", 32'h0, {31'h0, IRQ});
        apb(1, 12'h028, 1); @(posedge CLK);
        chk("irq", 32'h1, {31'h0, IRQ});
        apb(0, 12'h024, 0);
        chk("irq status", 32'h1, {31'h0, q[0]});
        apb(1, 12'h024, 1); @(posedge CLK);
        chk("irq", 32'h0, {31'h0, IRQ});
        results();
    end
endmodule : autoreclose_zone_coordination_tb
